// file: shared/tpg_pkg.sv
// constants shared by the pulse generator and width capture timer
package tpg_pkg;

   // ****************************************
   // register byte addresses
   // ****************************************
   localparam logic [7:0] ADDR_COUNT      = 8'h00;
   localparam logic [7:0] ADDR_CMP_FIRST  = 8'h04;
   localparam logic [7:0] ADDR_CMP_SECOND = 8'h08;
   localparam logic [7:0] ADDR_OUT_CTRL   = 8'h0C;
   localparam logic [7:0] ADDR_MODE_CTRL  = 8'h10;
   localparam logic [7:0] ADDR_CAP_CTRL   = 8'h14;
   localparam logic [7:0] ADDR_EDGE_SEL   = 8'h18;
   localparam logic [7:0] ADDR_PRESCALE   = 8'h1C;

   // ****************************************
   // field positions
   // ****************************************
   localparam int MC_OVERFLOW   = 0;
   localparam int MC_MODE_LO    = 2;
   localparam int MC_MODE_HI    = 3;
   localparam int OC_OUT_EN     = 0;
   localparam int OC_INV_FIRST  = 1;
   localparam int OC_LEVEL_CLR  = 2;
   localparam int OC_LEVEL_SET  = 3;
   localparam int OC_INV_SECOND = 4;
   localparam int OC_SP_EN      = 5;
   localparam int OC_SP_TRIG    = 6;
   localparam int CC_FIRST_CAP  = 0;
   localparam int CC_FIRST_SRC  = 1;
   localparam int CC_SECOND_CAP = 2;
   localparam int ES_FIRST_LO   = 0;
   localparam int ES_SECOND_LO  = 2;

   // ****************************************
   // reset values and limits
   // ****************************************
   localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
   localparam logic [15:0] COUNT_ZERO     = 16'h0000;
   localparam logic [5:0]  OUT_CTRL_RST   = 6'h00;
   localparam logic [2:0]  CAP_CTRL_RST   = 3'h0;
   localparam logic [3:0]  EDGE_SEL_RST   = 4'h0;
   localparam logic [3:0]  PRESCALE_RST   = 4'h0;
   localparam logic [31:0] RDATA_ZERO     = 32'h0000_0000;

   // ****************************************
   // counting modes and edge selections
   // ****************************************
   localparam logic [1:0] MODE_STOP  = 2'h0;
   localparam logic [1:0] MODE_FREE  = 2'h1;
   localparam logic [1:0] MODE_EDGE  = 2'h2;
   localparam logic [1:0] MODE_MATCH = 2'h3;

   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_NONE = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   typedef enum logic [1:0] {SP_IDLE, SP_DELAY, SP_ACTIVE} tpg_sp_state_e;

endpackage

// file: shared/tpg_edge_if.sv
// edge events passed from an input detector to the timer core
`timescale 1ns/100ps
interface tpg_edge_if;
   logic valid;
   logic opposite;
   modport det  (output valid, output opposite);
   modport core (input valid, input opposite);
endinterface

// file: src/tpg_edge_det.sv
// synchroniser and selectable edge detector for one capture input
`timescale 1ns/100ps
module tpg_edge_det
   import tpg_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       pin,
   input  wire logic [1:0] sel,
   tpg_edge_if.det         ev
);
   logic sync1_reg;
   logic sync2_reg;
   logic last_reg;
   logic rise;
   logic fall;

   // the first stage feeds the second only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         last_reg  <= 1'b0;
      end else begin
         sync1_reg <= pin;
         sync2_reg <= sync1_reg;
         last_reg  <= sync2_reg;
      end
   end

   assign rise = sync2_reg & ~last_reg;
   assign fall = ~sync2_reg & last_reg;

   always_comb begin
      ev.valid    = 1'b0;
      ev.opposite = 1'b0;
      unique case (sel)
         EDGE_FALL: begin
            ev.valid    = fall;
            ev.opposite = rise;
         end
         EDGE_RISE: begin
            ev.valid    = rise;
            ev.opposite = fall;
         end
         EDGE_NONE: begin
            ev.valid    = 1'b0;
         end
         EDGE_BOTH: begin
            ev.valid    = rise | fall;
         end
      endcase
   end
endmodule

// file: src/tpg_prescaler.sv
// count clock divider: one-cycle tick every (div + 1) pclk cycles
`timescale 1ns/100ps
module tpg_prescaler (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       run,
   input  wire logic [3:0] div,
   output logic            tick
);
   logic [3:0] cnt_reg;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= 4'h0;
      end else if (!run || cnt_reg >= div) begin
         cnt_reg <= 4'h0;
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end

   assign tick = run && (cnt_reg >= div);
endmodule

// file: src/tpg_timer.sv
// 16-bit timer channel: periodic pulse, single pulse and width capture
//
// Notes on behaviour
// - match-and-restart mode drives the periodic pulse on the timer output
// - period is first compare plus one counts; high time second plus one
// - count equal to first compare raises the first match pulse
// - count equal to second compare raises the second match pulse
// - single pulse needs free-run or edge-restart mode and enable bit 5
// - soft trigger bit 6 or first input edge restarts counter, one pulse
// - in single pulse, first match raises its pulse and inverts output
// - in single pulse, second match raises its pulse and inverts output
// - pulse starts first+1 counts after trigger, lasts second-first counts
// - two-input capture: first input to second reg, second input to first
// - one-input free-run: opposite edge to first reg, selected to second
// - edge-restart mode: opposite to first, selected to second and clear
// - capture into second register by first input raises second match
// - first register capture source selects first or second input
// - count past maximum sets overflow, wraps to zero, keeps counting
// - reading the counter returns the live count without disturbing it
`timescale 1ns/100ps
module tpg_timer
   import tpg_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        capture_input_first,
   input  wire logic        capture_input_second,
   output logic             timer_output_pin,
   output logic             match_irq_first,
   output logic             match_irq_second
);

   // ****************************************
   // registers and state
   // ****************************************
   logic [15:0]   count_reg;
   logic [15:0]   cmp_first_reg;
   logic [15:0]   cmp_second_reg;
   logic [5:0]    out_ctrl_reg;
   logic [1:0]    count_mode_reg;
   logic          overflow_flag_reg;
   logic [2:0]    cap_ctrl_reg;
   logic [3:0]    edge_sel_reg;
   logic [3:0]    prescale_reg;
   logic          level_reg;
   logic          pin_reg;
   logic          irq_first_reg;
   logic          irq_second_reg;
   logic [31:0]   prdata_reg;
   logic          pready_reg;
   logic          pslverr_reg;
   tpg_sp_state_e sp_state_reg;
   tpg_sp_state_e sp_state_next;

   // ****************************************
   // decoded controls
   // ****************************************
   logic        wr_en;
   logic        setup;
   logic [31:0] rdata_next;
   logic        addr_hit;
   logic        running;
   logic        tick;
   logic        sp_enable;
   logic        soft_trig;
   logic        sp_trigger;
   logic        edge_clear;
   logic        clear_start;
   logic        capturing_mode;
   logic        cap_first_en;
   logic        cap_second_en;
   logic        cap_first_evt;
   logic        cap_second_evt;
   logic        match_first;
   logic        match_second;
   logic        at_max;

   tpg_edge_if first_ev ();
   tpg_edge_if second_ev ();

   // ****************************************
   // input edge detection and count clock
   // ****************************************
   tpg_edge_det u_first_det (
      .clk  (pclk),
      .rstn (presetn),
      .pin  (capture_input_first),
      .sel  (edge_sel_reg[ES_FIRST_LO +: 2]),
      .ev   (first_ev)
   );

   tpg_edge_det u_second_det (
      .clk  (pclk),
      .rstn (presetn),
      .pin  (capture_input_second),
      .sel  (edge_sel_reg[ES_SECOND_LO +: 2]),
      .ev   (second_ev)
   );

   tpg_prescaler u_prescaler (
      .clk  (pclk),
      .rstn (presetn),
      .run  (running),
      .div  (prescale_reg),
      .tick (tick)
   );

   // ****************************************
   // bus decode
   // ****************************************
   // zero-wait slave: pready rises in the first access cycle
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pwrite & pready_reg;

   always_comb begin
      rdata_next = RDATA_ZERO;
      addr_hit   = 1'b1;
      unique case (paddr)
         ADDR_COUNT:      rdata_next[15:0] = count_reg;
         ADDR_CMP_FIRST:  rdata_next[15:0] = cmp_first_reg;
         ADDR_CMP_SECOND: rdata_next[15:0] = cmp_second_reg;
         ADDR_OUT_CTRL:   rdata_next[5:0]  = out_ctrl_reg;
         ADDR_MODE_CTRL: begin
            rdata_next[MC_MODE_HI:MC_MODE_LO] = count_mode_reg;
            rdata_next[MC_OVERFLOW]           = overflow_flag_reg;
         end
         ADDR_CAP_CTRL:   rdata_next[2:0]  = cap_ctrl_reg;
         ADDR_EDGE_SEL:   rdata_next[3:0]  = edge_sel_reg;
         ADDR_PRESCALE:   rdata_next[3:0]  = prescale_reg;
         default:         addr_hit         = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= RDATA_ZERO;
      end else begin
         pready_reg  <= setup;
         pslverr_reg <= setup & ~addr_hit;
         if (setup) begin
            prdata_reg <= pwrite ? RDATA_ZERO : rdata_next;
         end
      end
   end

   // ****************************************
   // event terms
   // ****************************************
   assign running        = count_mode_reg != MODE_STOP;
   assign capturing_mode = (count_mode_reg == MODE_FREE) || (count_mode_reg == MODE_EDGE);
   assign sp_enable      = capturing_mode & out_ctrl_reg[OC_SP_EN];
   // the trigger bit is not stored: it acts in the write cycle and reads zero
   assign soft_trig      = wr_en & (paddr == ADDR_OUT_CTRL) & pwdata[OC_SP_TRIG];
   assign sp_trigger     = sp_enable & (soft_trig | first_ev.valid);
   assign edge_clear     = (count_mode_reg == MODE_EDGE) & first_ev.valid;
   assign clear_start    = sp_trigger | edge_clear;

   // mode 11 always compares on the first register
   assign cap_first_en   = capturing_mode & cap_ctrl_reg[CC_FIRST_CAP];
   assign cap_second_en  = capturing_mode & cap_ctrl_reg[CC_SECOND_CAP];
   // source bit picks the second input or the first input's opposite edge
   assign cap_first_evt  = cap_first_en &
                           (cap_ctrl_reg[CC_FIRST_SRC] ? first_ev.opposite
                                                       : second_ev.valid);
   assign cap_second_evt = cap_second_en & first_ev.valid;

   // a match is seen at the end of the count period holding the value
   assign match_first  = tick & ~cap_first_en & (count_reg == cmp_first_reg);
   assign match_second = tick & ~cap_second_en & (count_reg == cmp_second_reg);
   assign at_max       = tick & (count_reg == COUNT_MAX);

   // ****************************************
   // counter and overflow
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= COUNT_ZERO;
      end else if (!running) begin
         count_reg <= COUNT_ZERO;
      end else if (clear_start) begin
         count_reg <= COUNT_ZERO;
      end else if (tick) begin
         if (count_mode_reg == MODE_MATCH && count_reg == cmp_first_reg) begin
            count_reg <= COUNT_ZERO;
         end else begin
            count_reg <= count_reg + 16'h0001;
         end
      end
   end

   // a hardware set in the cycle of a software clear wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_flag_reg <= 1'b0;
      end else if (running && at_max) begin
         overflow_flag_reg <= 1'b1;
      end else if (wr_en && paddr == ADDR_MODE_CTRL && !pwdata[MC_OVERFLOW]) begin
         overflow_flag_reg <= 1'b0;
      end
   end

   // ****************************************
   // control registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_mode_reg <= MODE_STOP;
         out_ctrl_reg   <= OUT_CTRL_RST;
         cap_ctrl_reg   <= CAP_CTRL_RST;
         edge_sel_reg   <= EDGE_SEL_RST;
         prescale_reg   <= PRESCALE_RST;
      end else if (wr_en) begin
         unique case (paddr)
            ADDR_MODE_CTRL: count_mode_reg <= pwdata[MC_MODE_HI:MC_MODE_LO];
            ADDR_OUT_CTRL:  out_ctrl_reg   <= pwdata[5:0];
            ADDR_CAP_CTRL:  cap_ctrl_reg   <= pwdata[2:0];
            ADDR_EDGE_SEL:  edge_sel_reg   <= pwdata[3:0];
            ADDR_PRESCALE:  prescale_reg   <= pwdata[3:0];
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // compare / capture registers
   // ****************************************
   // a capture in the cycle of a software write wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_first_reg <= COUNT_ZERO;
      end else if (cap_first_evt) begin
         cmp_first_reg <= count_reg;
      end else if (wr_en && paddr == ADDR_CMP_FIRST) begin
         cmp_first_reg <= pwdata[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_second_reg <= COUNT_ZERO;
      end else if (cap_second_evt) begin
         cmp_second_reg <= count_reg;
      end else if (wr_en && paddr == ADDR_CMP_SECOND) begin
         cmp_second_reg <= pwdata[15:0];
      end
   end

   // ****************************************
   // match / capture pulses
   // ****************************************
   // opposite-edge captures give no pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_first_reg  <= 1'b0;
         irq_second_reg <= 1'b0;
      end else begin
         irq_first_reg  <= running &
                           (match_first | (cap_first_evt & ~cap_ctrl_reg[CC_FIRST_SRC]));
         irq_second_reg <= running & (match_second | cap_second_evt);
      end
   end

   // ****************************************
   // single pulse sequencer
   // ****************************************
   // a retrigger during the pulse restarts the delay; users must avoid it
   always_comb begin
      sp_state_next = sp_state_reg;
      if (!sp_enable) begin
         sp_state_next = SP_IDLE;
      end else if (sp_trigger) begin
         sp_state_next = SP_DELAY;
      end else begin
         unique case (sp_state_reg)
            SP_IDLE: begin
               sp_state_next = SP_IDLE;
            end
            SP_DELAY: begin
               if (match_first) begin
                  sp_state_next = SP_ACTIVE;
               end
            end
            SP_ACTIVE: begin
               if (match_second) begin
                  sp_state_next = SP_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_state_reg <= SP_IDLE;
      end else begin
         sp_state_reg <= sp_state_next;
      end
   end

   // ****************************************
   // output level
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_reg <= 1'b0;
      end else if (!running) begin
         // default level is only steerable while stopped
         if (out_ctrl_reg[OC_LEVEL_SET] && !out_ctrl_reg[OC_LEVEL_CLR]) begin
            level_reg <= 1'b1;
         end else if (out_ctrl_reg[OC_LEVEL_CLR] && !out_ctrl_reg[OC_LEVEL_SET]) begin
            level_reg <= 1'b0;
         end
         // starting the periodic mode begins with the active phase
         if (wr_en && paddr == ADDR_MODE_CTRL &&
             pwdata[MC_MODE_HI:MC_MODE_LO] == MODE_MATCH) begin
            level_reg <= 1'b1;
         end
      end else if (count_mode_reg == MODE_MATCH) begin
         // with second below first, set/clear here equals an inversion
         if (match_first) begin
            level_reg <= 1'b1;
         end else if (match_second) begin
            level_reg <= 1'b0;
         end
      end else if (sp_enable) begin
         if (sp_trigger) begin
            level_reg <= 1'b0;
         end else if ((sp_state_reg == SP_DELAY && match_first) ||
                      (sp_state_reg == SP_ACTIVE && match_second)) begin
            level_reg <= ~level_reg;
         end
      end else begin
         level_reg <= level_reg ^ (match_first & out_ctrl_reg[OC_INV_FIRST])
                                ^ (match_second & out_ctrl_reg[OC_INV_SECOND]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_reg <= 1'b0;
      end else begin
         pin_reg <= out_ctrl_reg[OC_OUT_EN] & level_reg;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign prdata           = prdata_reg;
   assign pready           = pready_reg;
   assign pslverr          = pslverr_reg;
   assign timer_output_pin = pin_reg;
   assign match_irq_first  = irq_first_reg;
   assign match_irq_second = irq_second_reg;

endmodule

// file: dv/tpg_timer_checker.sv
// port assertions for the timer channel
`timescale 1ns/100ps
module tpg_timer_checker
   import tpg_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        timer_output_pin,
   input wire logic        match_irq_first,
   input wire logic        match_irq_second
);
   logic [1:0] mode_reg;
   logic       oe_reg;
   // shadow of mode and output enable, so the periodic set check only applies when driven
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= MODE_STOP;
         oe_reg   <= 1'b0;
      end else if (psel && penable && pwrite && pready) begin
         if (paddr == ADDR_MODE_CTRL)
            mode_reg <= pwdata[MC_MODE_HI:MC_MODE_LO];
         if (paddr == ADDR_OUT_CTRL)
            oe_reg <= pwdata[OC_OUT_EN];
      end
   end
   // ****************************************
   // assertions
   // ****************************************
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   bus_ready_a: assert property (psel && penable |-> pready)
      else $error("no ready in access cycle");
   ready_idle_a: assert property (!penable |-> !pready)
      else $error("ready outside access");
   err_qual_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   unmapped_err_a: assert property (psel && penable && paddr > ADDR_PRESCALE
      |-> pslverr && prdata == RDATA_ZERO) else $error("unmapped access accepted");
   first_irq_a: assert property (match_irq_first |=> !match_irq_first)
      else $error("first match not a pulse");
   second_irq_a: assert property (match_irq_second |=> !match_irq_second)
      else $error("second match not a pulse");
   reset_quiet_a: assert property ($rose(presetn)
      |-> !timer_output_pin && !match_irq_first && !match_irq_second)
      else $error("outputs active after reset");
   periodic_set_a: assert property (mode_reg == MODE_MATCH && oe_reg && match_irq_first
      |-> ##[0:2] timer_output_pin) else $error("periodic output not set");
   periodic_clear_a: assert property (mode_reg == MODE_MATCH && match_irq_second
      |-> ##[0:2] !timer_output_pin) else $error("periodic output not cleared");
endmodule
bind tpg_timer tpg_timer_checker chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .timer_output_pin(timer_output_pin), .match_irq_first(match_irq_first),
   .match_irq_second(match_irq_second));

// file: dv/tpg_pin_src.sv
// external source of the capture inputs and load on the timer output
`timescale 1ns/100ps
module tpg_pin_src (
   input  wire logic pclk,
   output logic      cap_first,
   output logic      cap_second,
   input  wire logic out_pin,
   output int        hi_len,
   output int        lo_len
);
   int   run_len = 0;
   logic last_lvl = 1'b0;
   initial begin
      cap_first = 1'b0;
      cap_second = 1'b0;
   end
   // run lengths of each output level, latched when the level changes
   always @(posedge pclk) begin
      if (out_pin !== last_lvl) begin
         if (last_lvl === 1'b1)
            hi_len = run_len;
         else
            lo_len = run_len;
         run_len = 1;
      end else
         run_len = run_len + 1;
      last_lvl = out_pin;
   end
   // pins move only when the bench asks, never during a pulse in flight
   task automatic drive(input bit sel, input bit lvl);
      @(posedge pclk);
      if (sel)
         cap_second <= lvl;
      else
         cap_first <= lvl;
   endtask
endmodule

// file: dv/test_timer_pulse_gen_and_width_capture.sv
// self-checking bench for the timer channel
`timescale 1ns/100ps
module test_timer_pulse_gen_and_width_capture import tpg_pkg::*;;
   logic        pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, q;
   logic        pready, pslverr, err, cap_first, cap_second, pin, irq1, irq2;
   int          err_total = 0, comparisons = 0, hi_len, lo_len, n1, n2, m, n, d;
   tpg_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .capture_input_first(cap_first), .capture_input_second(cap_second),
      .timer_output_pin(pin), .match_irq_first(irq1), .match_irq_second(irq2));
   tpg_pin_src src_u (.pclk(pclk), .cap_first(cap_first), .cap_second(cap_second),
      .out_pin(pin), .hi_len(hi_len), .lo_len(lo_len));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (irq1 === 1'b1) n1++;
      if (irq2 === 1'b1) n2++;
   end
   // ****************************************
   // bus and checking tasks
   // ****************************************
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] dat);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         chk(32'h0, 32'h1);
         close_out();
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   initial begin
      void'($urandom(32'hBDA4));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 9; i++) begin
         apb(0, 8'(i * 4), 32'h0);
         chk(rd, 32'h0);
         chk(32'(err), 32'(i == 8));
      end
      m = $urandom_range(12, 8);
      n = m + $urandom_range(9, 2);
      d = $urandom_range(40, 5);
      apb(1, ADDR_CMP_FIRST, m);
      apb(1, ADDR_CMP_SECOND, n);
      apb(1, ADDR_EDGE_SEL, 32'h1);
      // soft trigger in free-run, then an input edge in edge-restart mode
      for (int i = 0; i < 2; i++) begin
         apb(1, ADDR_OUT_CTRL, 32'h33);
         apb(1, ADDR_MODE_CTRL, i ? 32'h8 : 32'h4);
         n1 = 0;
         n2 = 0;
         if (i) src_u.drive(0, 1'b1);
         else begin
            apb(1, ADDR_OUT_CTRL, 32'h73);
            // the bus idle cycle and the output flop add two to the delay
            repeat (m + 1) @(posedge pclk);
            chk(32'(pin), 32'h0);
            @(posedge pclk);
            chk(32'(pin), 32'h1);
         end
         repeat (n + 12) @(posedge pclk);
         chk(hi_len, n - m);
         chk(n1, 1);
         chk(n2, 1);
         apb(1, ADDR_MODE_CTRL, 32'h0);
      end
      src_u.drive(0, 1'b0);
      apb(1, ADDR_CMP_FIRST, n);
      apb(1, ADDR_CMP_SECOND, m);
      apb(1, ADDR_OUT_CTRL, 32'h13);
      apb(1, ADDR_MODE_CTRL, 32'hC);
      repeat (3 * n + 6) @(posedge pclk);
      chk(hi_len, m + 1);
      chk(lo_len, n - m);
      apb(1, ADDR_MODE_CTRL, 32'h0);
      apb(1, ADDR_OUT_CTRL, 32'h0);
      apb(1, ADDR_EDGE_SEL, 32'h5);
      apb(1, ADDR_MODE_CTRL, 32'h4);
      // edge pairs d cycles apart, so synchroniser latency cancels out
      for (int i = 0; i < 2; i++) begin
         apb(1, ADDR_CAP_CTRL, i ? 32'h7 : 32'h5);
         n1 = 0;
         n2 = 0;
         src_u.drive(0, !i);
         repeat (d - 1) @(posedge pclk);
         src_u.drive(!i, 1'b1);
         repeat (8) @(posedge pclk);
         apb(0, ADDR_CMP_FIRST, 32'h0);
         q = rd;
         apb(0, ADDR_CMP_SECOND, 32'h0);
         chk(i ? rd - q : q - rd, d);
         chk(n2, 1);
         chk(n1, 32'(!i));
      end
      apb(0, ADDR_COUNT, 32'h0);
      q = rd;
      apb(0, ADDR_COUNT, 32'h0);
      chk(rd - q, 32'h3);
      repeat (65600) @(posedge pclk);
      apb(0, ADDR_MODE_CTRL, 32'h0);
      chk(rd, 32'h5);
      apb(1, ADDR_MODE_CTRL, 32'h4);
      apb(0, ADDR_MODE_CTRL, 32'h0);
      chk(rd, 32'h4);
      // edge-restart: opposite edge then selected edge, d cycles apart
      apb(1, ADDR_MODE_CTRL, 32'h8);
      src_u.drive(0, 1'b0);
      repeat (d - 1) @(posedge pclk);
      src_u.drive(0, 1'b1);
      // the selected edge clears the count three cycles after the pin moves
      repeat (8) @(posedge pclk);
      apb(0, ADDR_COUNT, 32'h0);
      chk(rd, 32'h5);
      apb(0, ADDR_CMP_FIRST, 32'h0);
      q = rd;
      apb(0, ADDR_CMP_SECOND, 32'h0);
      chk(rd - q, d);
      close_out();
   end
endmodule
